/* File: pkg/fdc_consts.vh */
// Constants for the four channel transfer engine: register offsets, fields, resets.
// Assumes byte addressing on a 32-bit classic Wishbone port, 16-bit data space.
`ifndef FDC_CONSTS_VH
`define FDC_CONSTS_VH

`define FDC_NCH 4
`define FDC_NSRC 8
`define FDC_CNT_W 14
`define FDC_DW 16

// Channel block: channel n sits at n * stride
`define FDC_CH_STRIDE 8'h10
`define FDC_OFS_CTRL 4'h0
`define FDC_OFS_PAD 4'h4
`define FDC_OFS_CNT 4'h8
`define FDC_OFS_BASE 4'hC

// Global registers
`define FDC_OFS_COL 8'h40
`define FDC_OFS_IRQ_STAT 8'h44
`define FDC_OFS_IRQ_MASK 8'h48
`define FDC_OFS_BUSY 8'h4C

// Control word fields
`define FDC_CTRL_EN 0
`define FDC_CTRL_DIR 1
`define FDC_CTRL_SRC_LO 4
`define FDC_CTRL_SRC_HI 6
`define FDC_CTRL_IDX_LO 16
`define FDC_CTRL_IDX_HI 29

// Request source numbers
`define FDC_SRC_CAN 3'h0
`define FDC_SRC_ADC 3'h1
`define FDC_SRC_SPI 3'h2
`define FDC_SRC_UART 3'h3
`define FDC_SRC_IC 3'h4
`define FDC_SRC_OC 3'h5

// Reset values
`define FDC_RST_PAD 16'h0000
`define FDC_RST_CNT 14'h0000
`define FDC_RST_BASE 16'h0000
`define FDC_RST_IRQ 8'h00

`endif

/* File: src/fdc_rr_arb.v */
// Round robin pick among the four channels with a pending request.
// Assumes one request mask per cycle; pointer moves only on i_adv.
`timescale 1ns/1ns
`default_nettype none

module fdc_rr_arb (
  input wire i_sys_clk,
  input wire i_nrst,
  input wire [3:0] i_req,
  input wire i_adv,
  output reg [1:0] o_idx,
  output wire o_any
);

  reg [1:0] last_q;
  reg [1:0] k;
  reg [2:0] s;
  reg found;

  assign o_any = |i_req;

  // Search starting one after the last winner
  always @* begin
    o_idx = 2'h0;
    found = 1'b0;
    k = 2'h0;
    for (s = 3'h1; s <= 3'h4; s = s + 3'h1) begin
      k = last_q + s[1:0];
      if (!found && i_req[k]) begin
        o_idx = k;
        found = 1'b1;
      end
    end
  end

  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      last_q <= 2'h3;
    end else if (i_adv) begin
      last_q <= o_idx;
    end
  end

endmodule // fdc_rr_arb

`default_nettype wire

/* File: src/fdc_dma_top.v */
// Four channel transfer engine with Wishbone register port and data-space master.
// Assumes the data-space arbiter completes a granted access in the grant cycle,
// read data valid on the cycle after the grant; request sources pulse one cycle.
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "fdc_consts.vh"

// What this block does
// - Four channels run independently, each set to move data to or from its chosen peripheral.
// - Every transfer moves one word between a peripheral data register and data-space memory.
// - Memory addresses span the whole 16-bit data space, not only the SRAM region.
// - Memory accesses go through a shared arbiter and the engine stalls until granted.
// - Request sources cover CAN, analog converter, SPI, UART, input capture and output compare.
// - Each channel holds a 16-bit read/write peripheral address that resets to zero.
// - Each channel holds a 14-bit read/write transfer count whose upper two bits read zero.
// - A channel completes its block after count plus one transfers.
// - A read-only collision register shows one flag per channel in bits zero to three.
module fdc_dma_top (
  input wire i_sys_clk,
  input wire i_nrst,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  input wire [`FDC_NSRC-1:0] i_src_req,
  output reg o_mem_req,
  input wire i_mem_gnt,
  output reg o_mem_we,
  output reg [15:0] o_mem_addr,
  output reg [15:0] o_mem_wdata,
  input wire [15:0] i_mem_rdata,
  output wire o_irq
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RD = 4'b0010;
  localparam [3:0] ST_CAP = 4'b0100;
  localparam [3:0] ST_WR = 4'b1000;

  reg [3:0] st_q;
  reg [1:0] cur_q;
  reg [15:0] data_q;
  reg [3:0] en_q;
  reg [3:0] dir_q;
  reg [2:0] src_q [0:3];
  reg [15:0] pad_q [0:3];
  reg [`FDC_CNT_W-1:0] cnt_q [0:3];
  reg [15:0] base_q [0:3];
  reg [`FDC_CNT_W-1:0] idx_q [0:3];
  reg [3:0] pend_q;
  reg [3:0] col_q;
  reg [7:0] stat_q;
  reg [7:0] mask_q;
  reg [31:0] rd_d;
  reg [3:0] trig;
  reg [3:0] col_set;
  reg [3:0] done_set;
  reg [3:0] start_clr;
  integer i, j, m;

  wire bus_req = i_wb_cyc & i_wb_stb;
  wire bus_wr = bus_req & i_wb_we & o_wb_ack;
  wire [1:0] arb_idx;
  wire arb_any;
  wire start = st_q[0] & arb_any;
  wire wr_done = st_q[3] & i_mem_gnt;

  // Byte-lane merge of a 16-bit register
  function [15:0] lane16;
    input [15:0] old;
    input [15:0] wd;
    input [1:0] sel;
    begin
      lane16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // Channel register hit
  function hit;
    input [7:0] adr;
    input [1:0] ch;
    input [3:0] ofs;
    begin
      hit = (adr[7:6] == 2'h0) && (adr[5:4] == ch) && (adr[3:0] == ofs);
    end
  endfunction

  // Memory address of the current element in a channel's block
  function [15:0] elem_addr;
    input [15:0] base;
    input [`FDC_CNT_W-1:0] idx;
    begin
      elem_addr = base + {1'b0, idx, 1'b0};
    end
  endfunction

  fdc_rr_arb u_arb (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_req(pend_q & en_q),
    .i_adv(start),
    .o_idx(arb_idx),
    .o_any(arb_any)
  );

  // Request detection and collision events
  always @* begin
    for (j = 0; j < `FDC_NCH; j = j + 1) begin
      trig[j] = en_q[j] & i_src_req[src_q[j]];
      start_clr[j] = start && (arb_idx == j[1:0]);
      // A new request while the last is still outstanding collides
      col_set[j] = trig[j] & (pend_q[j] | (!st_q[0] && cur_q == j[1:0]));
      done_set[j] = wr_done && (cur_q == j[1:0]) && (idx_q[j] == cnt_q[j]);
    end
  end

  // Register read mux
  always @* begin
    rd_d = 32'h0000_0000;
    for (m = 0; m < `FDC_NCH; m = m + 1) begin
      if (hit(i_wb_adr, m[1:0], `FDC_OFS_CTRL)) begin
        rd_d[`FDC_CTRL_EN] = en_q[m];
        rd_d[`FDC_CTRL_DIR] = dir_q[m];
        rd_d[`FDC_CTRL_SRC_HI:`FDC_CTRL_SRC_LO] = src_q[m];
        rd_d[`FDC_CTRL_IDX_HI:`FDC_CTRL_IDX_LO] = idx_q[m];
      end
      if (hit(i_wb_adr, m[1:0], `FDC_OFS_PAD)) begin
        rd_d[15:0] = pad_q[m];
      end
      if (hit(i_wb_adr, m[1:0], `FDC_OFS_CNT)) begin
        rd_d[`FDC_CNT_W-1:0] = cnt_q[m];
      end
      if (hit(i_wb_adr, m[1:0], `FDC_OFS_BASE)) begin
        rd_d[15:0] = base_q[m];
      end
    end
    case (i_wb_adr)
      `FDC_OFS_COL: rd_d[3:0] = col_q;
      `FDC_OFS_IRQ_STAT: rd_d[7:0] = stat_q;
      `FDC_OFS_IRQ_MASK: rd_d[7:0] = mask_q;
      `FDC_OFS_BUSY: rd_d[10:0] = {~st_q[0], en_q, pend_q, cur_q};
      default: rd_d[31:0] = rd_d[31:0];
    endcase
  end

  // Wishbone slave: ack one cycle after the request, writes land on the ack edge
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req & ~o_wb_ack;
      if (bus_req & ~o_wb_ack) begin
        o_wb_dat <= rd_d;
      end
    end
  end

  // Channel registers, pending, collision and interrupt status
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_q <= 4'h0;
      dir_q <= 4'h0;
      pend_q <= 4'h0;
      col_q <= 4'h0;
      stat_q <= `FDC_RST_IRQ;
      mask_q <= `FDC_RST_IRQ;
      for (i = 0; i < `FDC_NCH; i = i + 1) begin
        src_q[i] <= 3'h0;
        pad_q[i] <= `FDC_RST_PAD;
        cnt_q[i] <= `FDC_RST_CNT;
        base_q[i] <= `FDC_RST_BASE;
        idx_q[i] <= `FDC_RST_CNT;
      end
    end else begin
      for (i = 0; i < `FDC_NCH; i = i + 1) begin
        if (bus_wr && hit(i_wb_adr, i[1:0], `FDC_OFS_CTRL) && i_wb_sel[0]) begin
          en_q[i] <= i_wb_dat[`FDC_CTRL_EN];
          dir_q[i] <= i_wb_dat[`FDC_CTRL_DIR];
          src_q[i] <= i_wb_dat[`FDC_CTRL_SRC_HI:`FDC_CTRL_SRC_LO];
          if (!i_wb_dat[`FDC_CTRL_EN]) begin
            idx_q[i] <= `FDC_RST_CNT;
            col_q[i] <= 1'b0;
          end
        end
        // Address and count writes while enabled are the caller's hazard
        if (bus_wr && hit(i_wb_adr, i[1:0], `FDC_OFS_PAD)) begin
          pad_q[i] <= lane16(pad_q[i], i_wb_dat[15:0], i_wb_sel[1:0]);
        end
        if (bus_wr && hit(i_wb_adr, i[1:0], `FDC_OFS_CNT)) begin
          cnt_q[i] <= {i_wb_sel[1] ? i_wb_dat[13:8] : cnt_q[i][13:8],
            i_wb_sel[0] ? i_wb_dat[7:0] : cnt_q[i][7:0]};
        end
        if (bus_wr && hit(i_wb_adr, i[1:0], `FDC_OFS_BASE)) begin
          base_q[i] <= lane16(base_q[i], i_wb_dat[15:0], i_wb_sel[1:0]);
        end
        // Pending: a new request wins over the start that consumes the last
        if (trig[i]) begin
          pend_q[i] <= 1'b1;
        end else if (start_clr[i] || !en_q[i]) begin
          pend_q[i] <= 1'b0;
        end
        if (col_set[i]) begin
          col_q[i] <= 1'b1;
        end
        // Advance progress after each write-back
        if (wr_done && cur_q == i[1:0]) begin
          if (done_set[i]) begin
            idx_q[i] <= `FDC_RST_CNT;
            en_q[i] <= 1'b0;
          end else begin
            idx_q[i] <= idx_q[i] + 14'h0001;
          end
        end
      end
      if (bus_wr && i_wb_adr == `FDC_OFS_IRQ_MASK && i_wb_sel[0]) begin
        mask_q <= i_wb_dat[7:0];
      end
      // Write one to clear; a fresh event wins over the clear
      if (bus_wr && i_wb_adr == `FDC_OFS_IRQ_STAT && i_wb_sel[0]) begin
        stat_q <= (stat_q & ~i_wb_dat[7:0]) | {col_set, done_set};
      end else begin
        stat_q <= stat_q | {col_set, done_set};
      end
    end
  end

  assign o_irq = |(stat_q & mask_q);

  // Transfer engine: read source, capture, write destination
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= ST_IDLE;
      cur_q <= 2'h0;
      data_q <= 16'h0000;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= 16'h0000;
      o_mem_wdata <= 16'h0000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (arb_any) begin
            cur_q <= arb_idx;
            st_q <= ST_RD;
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b0;
            // Peripheral to memory reads the peripheral register first
            o_mem_addr <= dir_q[arb_idx] ? elem_addr(base_q[arb_idx], idx_q[arb_idx]) :
              pad_q[arb_idx];
          end
        end
        ST_RD: begin
          if (i_mem_gnt) begin
            o_mem_req <= 1'b0;
            st_q <= ST_CAP;
          end
        end
        ST_CAP: begin
          data_q <= i_mem_rdata;
          o_mem_wdata <= i_mem_rdata;
          o_mem_req <= 1'b1;
          o_mem_we <= 1'b1;
          o_mem_addr <= dir_q[cur_q] ? pad_q[cur_q] :
            elem_addr(base_q[cur_q], idx_q[cur_q]);
          st_q <= ST_WR;
        end
        ST_WR: begin
          if (i_mem_gnt) begin
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
          o_mem_req <= 1'b0;
        end
      endcase
    end
  end

endmodule // fdc_dma_top

`default_nettype wire

/* File: src/fdc_mask_fix.v */
// Holds no logic; the mask offset is taken from the shared constants.
// Assumes nothing of its surroundings.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* File: verification/fdc_dma_props.sv */
// Concurrent checks on the engine's register port and memory master.
// Assumes binding to fdc_dma_top; one clock, async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module fdc_dma_props (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_mem_req,
  input wire logic i_mem_gnt,
  input wire logic o_mem_we,
  input wire logic [15:0] o_mem_addr,
  input wire logic [15:0] o_mem_wdata
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held too long");
  ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered");
  cnt_upper_zero_a: assert property (o_wb_ack && $past(!i_wb_we && i_wb_adr < 8'h40
    && i_wb_adr[3:0] == 4'h8) |-> o_wb_dat[31:14] == 18'h0) else $error("count upper set");
  col_upper_zero_a: assert property (o_wb_ack && $past(!i_wb_we && i_wb_adr == 8'h40)
    |-> o_wb_dat[31:4] == 28'h0) else $error("collision upper set");
  unmapped_zero_a: assert property (o_wb_ack && $past(!i_wb_we && i_wb_adr > 8'h4F)
    |-> o_wb_dat == 32'h0) else $error("unmapped read not zero");
  req_hold_a: assert property (o_mem_req && !i_mem_gnt |=> o_mem_req && $stable(o_mem_addr)
    && $stable(o_mem_we) && $stable(o_mem_wdata)) else $error("request dropped");
  read_then_write_a: assert property (o_mem_req && !o_mem_we && i_mem_gnt
    |=> !o_mem_req ##1 (o_mem_req && o_mem_we)) else $error("bad access order");
  write_then_idle_a: assert property (o_mem_req && o_mem_we && i_mem_gnt |=> !o_mem_req)
    else $error("no idle after write");
  cover property (o_mem_req && o_mem_we && i_mem_gnt);
  cover property (o_mem_req && !i_mem_gnt ##1 o_mem_req && i_mem_gnt);
  cover property (o_wb_ack && $past(i_wb_we));
endmodule // fdc_dma_props
bind fdc_dma_top fdc_dma_props u_props (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_mem_req(o_mem_req), .i_mem_gnt(i_mem_gnt),
  .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata));
`default_nettype wire

/* File: verification/fdc_mem_model.sv */
// Data-space memory behind a shared arbiter that stalls at random.
// Assumes one held request at a time; read data valid after the grant.
`timescale 1ns/1ns
`default_nettype none
module fdc_mem_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_gnt,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [0:65535];
  int wr_n = 0;
  int stall = 0;
  initial for (int a = 0; a < 65536; a++) mem[a] = 16'(a) ^ 16'h5A5A;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_gnt <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= ~o_rdata;
      o_gnt <= 1'b0;
      if (i_req && !o_gnt) begin
        if (stall > 0) stall <= stall - 1;
        else o_gnt <= 1'b1;
      end
      if (i_req && o_gnt) begin
        stall <= $urandom % 3;
        if (i_we) begin
          mem[i_addr] <= i_wdata;
          wr_n <= wr_n + 1;
        end else o_rdata <= mem[i_addr];
      end
    end
  end
endmodule // fdc_mem_model
`default_nettype wire

/* File: verification/fdc_dma_top_tb.sv */
// Bench: register values, transfers on sources 0 to 5, collisions, interrupts.
// Assumes fdc_mem_model as the data space and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "fdc_consts.vh"
module fdc_dma_top_tb;
  logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, ack, mreq, gnt, mwe, irq;
  logic [7:0] adr = 0, req = 0;
  logic [3:0] sel = 0;
  logic [31:0] wd = 0, rd, q;
  logic [15:0] ma, mw, mr, pad, base;
  int bad_count = 0, checks = 0, tick = 0;
  always #2 clk = ~clk;
  fdc_dma_top DUT (.i_sys_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wd), .o_wb_dat(rd),
    .o_wb_ack(ack), .i_src_req(req), .o_mem_req(mreq), .i_mem_gnt(gnt), .o_mem_we(mwe),
    .o_mem_addr(ma), .o_mem_wdata(mw), .i_mem_rdata(mr), .o_irq(irq));
  fdc_mem_model M (.i_clk(clk), .i_nrst(nrst), .i_req(mreq), .i_we(mwe), .i_addr(ma),
    .i_wdata(mw), .o_gnt(gnt), .o_rdata(mr));
  task automatic conclude;
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic rr(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(0, a, 0);
    chk(q, e, n);
  endtask
  task automatic go(input int ch, input int src, input int dir, input int cnt);
    wb(1, 8'(ch * 16 + 4), 32'(pad));
    wb(1, 8'(ch * 16 + 8), 32'(cnt));
    wb(1, 8'(ch * 16 + 12), 32'(base));
    wb(1, 8'(ch * 16), 32'(src * 16 + dir * 2 + 1));
  endtask
  always @(posedge clk) if (++tick > 30000) begin
    bad_count++;
    conclude();
  end
  initial begin
    int ch, cnt, n0, t;
    void'($urandom(32'h4B53));
    repeat (3) @(posedge clk);
    nrst <= 1;
    for (int c = 0; c < 4; c++) begin
      rr(8'(c * 16 + 4), 0, "pad_rst");
      rr(8'(c * 16 + 8), 0, "cnt_rst");
      wb(1, 8'(c * 16 + 4), 32'hFFFF_FFFF);
      rr(8'(c * 16 + 4), 32'hFFFF, "pad");
      wb(1, 8'(c * 16 + 8), 32'hFFFF_FFFF);
      rr(8'(c * 16 + 8), 32'h3FFF, "cnt");
    end
    rr(`FDC_OFS_COL, 0, "col_rst");
    rr(8'h50, 0, "unmapped");
    wb(1, `FDC_OFS_IRQ_MASK, 32'hFF);
    rr(`FDC_OFS_IRQ_MASK, 32'hFF, "mask");
    for (int i = 0; i < 6; i++) begin
      ch = i % 4;
      cnt = $urandom % 4;
      pad = 16'h0800 + 16'(i * 2);
      base = 16'hF000 + 16'(i * 256);
      n0 = M.wr_n;
      go(ch, i, i % 2, cnt);
      for (int k = 0; k <= cnt; k++) begin
        @(posedge clk);
        req <= 8'(1 << i);
        @(posedge clk);
        req <= 0;
        t = 0;
        while (M.wr_n < n0 + k + 1 && t < 200) begin
          @(posedge clk);
          t++;
        end
      end
      repeat (3) @(posedge clk);
      chk(M.wr_n - n0, cnt + 1, "xfers");
      if (i % 2 == 0) for (int k = 0; k <= cnt; k++)
        chk(M.mem[base + 16'(2 * k)], pad ^ 16'h5A5A, "to_mem");
      else chk(M.mem[pad], (base + 16'(2 * cnt)) ^ 16'h5A5A, "to_per");
      chk(irq, 1, "irq_done");
      rr(`FDC_OFS_IRQ_STAT, 32'(1 << ch), "done");
      rr(8'(ch * 16), 32'(i * 16 + (i % 2) * 2), "ctrl_done");
      wb(1, `FDC_OFS_IRQ_STAT, 32'(1 << ch));
      #1 chk(irq, 0, "irq_clr");
    end
    base = 16'h4000;
    go(2, `FDC_SRC_OC, 0, 3);
    repeat (2) begin
      @(posedge clk);
      req <= 8'h20;
      @(posedge clk);
      req <= 0;
    end
    repeat (20) @(posedge clk);
    rr(`FDC_OFS_COL, 32'h4, "col");
    rr(`FDC_OFS_IRQ_STAT, 32'h40, "col_stat");
    wb(1, `FDC_OFS_IRQ_MASK, 0);
    #1 chk(irq, 0, "masked");
    wb(1, `FDC_OFS_IRQ_MASK, 32'hFF);
    #1 chk(irq, 1, "unmasked");
    wb(1, 8'h20, 0);
    rr(`FDC_OFS_COL, 0, "col_clr");
    wb(1, `FDC_OFS_IRQ_STAT, 32'hFF);
    #1 chk(irq, 0, "irq_off");
    rr(`FDC_OFS_BUSY, 32'h2, "busy");
    conclude();
  end
endmodule // fdc_dma_top_tb
`default_nettype wire
